// [design/psync_defines.vh]
`ifndef PSYNC_DEFINES_VH
`define PSYNC_DEFINES_VH

// word addresses on the register port
`define PSYNC_ADDR_CTRL 3'h0
`define PSYNC_ADDR_BIF 3'h1
`define PSYNC_ADDR_CORE 3'h2
`define PSYNC_ADDR_RSYNC 3'h3
`define PSYNC_ADDR_STAT 3'h4

// primary_control_reg fields
`define PSYNC_CTRL_SOFT_RESET_BIT 0
`define PSYNC_CTRL_ENABLE 1

// status word fields
`define PSYNC_STAT_READY 0
`define PSYNC_STAT_PEND_LO 8
`define PSYNC_STAT_BUSY 16

// sync channel indices
`define PSYNC_CH_ENABLE 0
`define PSYNC_CH_SOFT_RESET_BIT 1
`define PSYNC_CH_A 2
`define PSYNC_CH_B 3
`define PSYNC_CH_C 4
`define PSYNC_CH_RSYNC 5
`define PSYNC_NCH 6

// generic clock rising edges seen per synchronisation
`define PSYNC_GENERIC_CLOCK_SOURCE_EDGES 3'h6

// reset values
`define PSYNC_RST_BYTE 8'h00
`define PSYNC_RST_HALF 16'h0000
`define PSYNC_RST_WORD 32'h00000000

`endif

// [design/psync_chan.v]
`timescale 1ns/1ps
`default_nettype none
`include "psync_defines.vh"

module psync_chan (
    input wire ref_clk,
    input wire resetn,
    input wire start,
    input wire generic_clock_source_rise,
    output reg busy,
    output reg done
);

reg [2:0] cnt_r;

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        busy <= 1'b0;
        done <= 1'b0;
        cnt_r <= 3'h0;
    end else begin
        done <= 1'b0;
        if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                // an edge landing with the start counts, so the delay spread stays one period
                cnt_r <= generic_clock_source_rise ? 3'h1 : 3'h0;
            end
        end else if (generic_clock_source_rise) begin
            // finish on the last counted generic clock edge
            if (cnt_r == `PSYNC_GENERIC_CLOCK_SOURCE_EDGES - 3'h1) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end
end

endmodule
`default_nettype wire

// [design/psync_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "psync_defines.vh"

// Function
// - common soft reset write starts sync, busy
// - soft reset reads one, hardware clears later
// - writing zero to soft reset does nothing
// - soft reset completion never sets ready
// - common soft reset stalls writes, synced reads
// - bus-interface reads never stall during reset
// - sync delay five-six generic_clock_source plus bus cycles
// - crossing always done, even same clock
// - core writes synced, interface registers not
// - distributed write sets own busy bit
// - write to pending register discarded, error
// - different core registers sync in parallel
// - second byte of halfword discarded, error
// - word write updates each register independently
// - read-synced value tracked, reads immediate
// - ready flag only when all pending clear
// - enable syncs, reads new value, no ready
// - distributed soft reset busy bit, readback
// - masked interface reads zero, drops writes
// - common core write stalls conflicting accesses
// - common read-synced read stalls, no busy

module psync_top (
    input wire ref_clk,
    input wire resetn,
    input wire generic_clock_source_in,
    input wire scheme_dist,
    input wire if_masked,
    input wire bus_req,
    input wire bus_we,
    input wire [2:0] bus_addr,
    input wire [3:0] bus_be,
    input wire [31:0] bus_wdata,
    input wire [15:0] core_rsync_val,
    output reg bus_ready,
    output reg [31:0] bus_rdata,
    output reg bus_err,
    output reg core_enable,
    output reg [7:0] core_a,
    output reg [7:0] core_b,
    output reg [15:0] core_c,
    output reg core_reset,
    output reg sync_busy,
    output wire [5:0] sync_pending_flags
);

reg generic_clock_source_s1_r;
reg generic_clock_source_s2_r;
reg generic_clock_source_s3_r;
reg [15:0] cv_s1_r;
reg [15:0] cv_s2_r;
reg scheme_s1_r;
reg scheme_s2_r;
reg mask_s1_r;
reg mask_s2_r;
reg soft_reset_bit_r;
reg enable_r;
reg [31:0] bif_r;
reg [7:0] a_r;
reg [7:0] b_r;
reg [15:0] c_r;
reg [15:0] rs_cap_r;
reg [15:0] rs_hold_r;
reg rs_wait_r;
reg ready_r;
reg ready_pend_r;
reg [5:0] start_nxt;
reg err_nxt;
reg stall_nxt;
reg rs_need_nxt;
wire [5:0] busy;
wire [5:0] done;
wire generic_clock_source_rise;
wire take;
wire do_acc;
wire rs_fin;
wire cbusy;
wire wr_ok;
genvar gi;

assign sync_pending_flags = busy;

// generic clock enters as a pin: two flops, then edge detect
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        generic_clock_source_s1_r <= 1'b0;
        generic_clock_source_s2_r <= 1'b0;
        generic_clock_source_s3_r <= 1'b0;
        cv_s1_r <= `PSYNC_RST_HALF;
        cv_s2_r <= `PSYNC_RST_HALF;
        scheme_s1_r <= 1'b0;
        scheme_s2_r <= 1'b0;
        mask_s1_r <= 1'b0;
        mask_s2_r <= 1'b0;
    end else begin
        generic_clock_source_s1_r <= generic_clock_source_in;
        generic_clock_source_s2_r <= generic_clock_source_s1_r;
        generic_clock_source_s3_r <= generic_clock_source_s2_r;
        cv_s1_r <= core_rsync_val;
        cv_s2_r <= cv_s1_r;
        scheme_s1_r <= scheme_dist;
        scheme_s2_r <= scheme_s1_r;
        mask_s1_r <= if_masked;
        mask_s2_r <= mask_s1_r;
    end
end

// edges counted even when generic_clock_source equals the bus clock
assign generic_clock_source_rise = generic_clock_source_s2_r & ~generic_clock_source_s3_r;

// each channel waits a fixed count of generic_clock_source edges
generate
    for (gi = 0; gi < `PSYNC_NCH; gi = gi + 1) begin : g_ch
        psync_chan u_chan (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .start(start_nxt[gi]),
            .generic_clock_source_rise(generic_clock_source_rise),
            .busy(busy[gi]),
            .done(done[gi])
        );
    end
endgenerate

// read sync channel is excluded from the single flag
assign cbusy = |busy[4:0];
assign take = bus_req & ~bus_ready & ~rs_wait_r;
assign do_acc = take & ~stall_nxt & ~rs_need_nxt;
assign rs_fin = rs_wait_r & done[`PSYNC_CH_RSYNC];
assign wr_ok = do_acc & bus_we & ~mask_s2_r;

always @* begin
    stall_nxt = 1'b0;
    rs_need_nxt = 1'b0;
    if (bus_we && done[`PSYNC_CH_SOFT_RESET_BIT]) begin
        stall_nxt = 1'b1;
    end
    if (!scheme_s2_r && !mask_s2_r) begin
        // soft reset also holds interface writes
        if (bus_we && busy[`PSYNC_CH_SOFT_RESET_BIT] && bus_addr == `PSYNC_ADDR_BIF) begin
            stall_nxt = 1'b1;
        end
        // core writes wait for the pending sync
        if (bus_we && cbusy &&
            (bus_addr == `PSYNC_ADDR_CTRL || bus_addr == `PSYNC_ADDR_CORE)) begin
            stall_nxt = 1'b1;
        end
        // reading the register under write waits
        if (!bus_we && bus_addr == `PSYNC_ADDR_CORE && (|busy[4:2])) begin
            stall_nxt = 1'b1;
        end
        // read-synced reads wait for the flag
        if (!bus_we && bus_addr == `PSYNC_ADDR_RSYNC && cbusy) begin
            stall_nxt = 1'b1;
        end
        // then a fresh read sync of its own
        if (!bus_we && bus_addr == `PSYNC_ADDR_RSYNC && !cbusy) begin
            rs_need_nxt = 1'b1;
        end
    end
end

always @* begin
    start_nxt = 6'h00;
    err_nxt = 1'b0;
    if (take && rs_need_nxt && !busy[`PSYNC_CH_RSYNC]) begin
        start_nxt[`PSYNC_CH_RSYNC] = 1'b1;
    end
    // distributed read sync follows core value changes
    // the held copy catches up only at the end of the done cycle
    if (scheme_s2_r && !busy[`PSYNC_CH_RSYNC] && !done[`PSYNC_CH_RSYNC] &&
        cv_s2_r != rs_hold_r) begin
        start_nxt[`PSYNC_CH_RSYNC] = 1'b1;
    end
    if (wr_ok && bus_addr == `PSYNC_ADDR_CTRL && bus_be[0]) begin
        // zero or repeat writes start nothing
        if (bus_wdata[`PSYNC_CTRL_SOFT_RESET_BIT] && !soft_reset_bit_r) begin
            start_nxt[`PSYNC_CH_SOFT_RESET_BIT] = 1'b1;
        end
        if (bus_wdata[`PSYNC_CTRL_ENABLE] != enable_r) begin
            if (busy[`PSYNC_CH_ENABLE]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[`PSYNC_CH_ENABLE] = 1'b1;
            end
        end
    end
    if (wr_ok && bus_addr == `PSYNC_ADDR_CORE) begin
        // colliding writes are dropped with error
        if (bus_be[0]) begin
            if (busy[`PSYNC_CH_A]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[`PSYNC_CH_A] = 1'b1;
            end
        end
        // each lane only checks its own channel
        if (bus_be[1]) begin
            if (busy[`PSYNC_CH_B]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[`PSYNC_CH_B] = 1'b1;
            end
        end
        // halfword busy blocks its second byte
        if (bus_be[2] || bus_be[3]) begin
            if (busy[`PSYNC_CH_C]) begin
                err_nxt = 1'b1;
            end else begin
                start_nxt[`PSYNC_CH_C] = 1'b1;
            end
        end
    end
end

always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        soft_reset_bit_r <= 1'b0;
        enable_r <= 1'b0;
        bif_r <= `PSYNC_RST_WORD;
        a_r <= `PSYNC_RST_BYTE;
        b_r <= `PSYNC_RST_BYTE;
        c_r <= `PSYNC_RST_HALF;
        core_enable <= 1'b0;
        core_a <= `PSYNC_RST_BYTE;
        core_b <= `PSYNC_RST_BYTE;
        core_c <= `PSYNC_RST_HALF;
        core_reset <= 1'b0;
    end else begin
        core_reset <= 1'b0;
        if (done[`PSYNC_CH_SOFT_RESET_BIT]) begin
            // all but the ready and read sync registers back to reset first
            soft_reset_bit_r <= 1'b0;
            enable_r <= 1'b0;
            bif_r <= `PSYNC_RST_WORD;
            a_r <= `PSYNC_RST_BYTE;
            b_r <= `PSYNC_RST_BYTE;
            c_r <= `PSYNC_RST_HALF;
            core_enable <= 1'b0;
            core_a <= `PSYNC_RST_BYTE;
            core_b <= `PSYNC_RST_BYTE;
            core_c <= `PSYNC_RST_HALF;
            core_reset <= 1'b1;
        end else begin
            // soft reset bit reads one at once
            if (start_nxt[`PSYNC_CH_SOFT_RESET_BIT]) begin
                soft_reset_bit_r <= 1'b1;
            end
            // enable reads its new value at once
            if (start_nxt[`PSYNC_CH_ENABLE]) begin
                enable_r <= bus_wdata[`PSYNC_CTRL_ENABLE];
            end
            // interface register written with no sync
            if (wr_ok && bus_addr == `PSYNC_ADDR_BIF) begin
                if (bus_be[0]) bif_r[7:0] <= bus_wdata[7:0];
                if (bus_be[1]) bif_r[15:8] <= bus_wdata[15:8];
                if (bus_be[2]) bif_r[23:16] <= bus_wdata[23:16];
                if (bus_be[3]) bif_r[31:24] <= bus_wdata[31:24];
            end
            // lanes of one word land in separate registers
            if (start_nxt[`PSYNC_CH_A]) a_r <= bus_wdata[7:0];
            if (start_nxt[`PSYNC_CH_B]) b_r <= bus_wdata[15:8];
            if (start_nxt[`PSYNC_CH_C] && bus_be[2]) c_r[7:0] <= bus_wdata[23:16];
            if (start_nxt[`PSYNC_CH_C] && bus_be[3]) c_r[15:8] <= bus_wdata[31:24];
            // core copies change only when their sync lands
            if (done[`PSYNC_CH_ENABLE]) core_enable <= enable_r;
            if (done[`PSYNC_CH_A]) core_a <= a_r;
            if (done[`PSYNC_CH_B]) core_b <= b_r;
            if (done[`PSYNC_CH_C]) core_c <= c_r;
        end
    end
end

// read sync capture, ready flag and common busy
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        rs_cap_r <= `PSYNC_RST_HALF;
        rs_hold_r <= `PSYNC_RST_HALF;
        rs_wait_r <= 1'b0;
        ready_r <= 1'b0;
        ready_pend_r <= 1'b0;
        sync_busy <= 1'b0;
    end else begin
        // single flag follows write and reset syncs
        sync_busy <= (|start_nxt[4:0]) | (|busy[4:0]);
        if (start_nxt[`PSYNC_CH_RSYNC]) begin
            rs_cap_r <= cv_s2_r;
        end
        if (done[`PSYNC_CH_RSYNC]) begin
            rs_hold_r <= rs_cap_r;
        end
        if (take && rs_need_nxt && !busy[`PSYNC_CH_RSYNC]) begin
            rs_wait_r <= 1'b1;
        end else if (rs_fin) begin
            rs_wait_r <= 1'b0;
        end
        // reset and enable completions do not arm ready
        if (scheme_s2_r && (|done[5:2])) begin
            ready_pend_r <= 1'b1;
        end else if (ready_pend_r && busy == 6'h00) begin
            ready_pend_r <= 1'b0;
        end
        // set only with every pending bit clear; set wins
        if (ready_pend_r && busy == 6'h00) begin
            ready_r <= 1'b1;
        end else if (wr_ok && bus_addr == `PSYNC_ADDR_STAT && bus_be[0] &&
            bus_wdata[`PSYNC_STAT_READY]) begin
            ready_r <= 1'b0;
        end
    end
end

// answer path
always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        bus_ready <= 1'b0;
        bus_rdata <= `PSYNC_RST_WORD;
        bus_err <= 1'b0;
    end else begin
        bus_ready <= do_acc | rs_fin;
        bus_err <= do_acc & err_nxt;
        bus_rdata <= `PSYNC_RST_WORD;
        if (rs_fin) begin
            bus_rdata <= {16'h0000, rs_cap_r};
        end else if (do_acc && !bus_we && !mask_s2_r) begin
            case (bus_addr)
                `PSYNC_ADDR_CTRL: bus_rdata <= {30'h00000000, enable_r, soft_reset_bit_r};
                `PSYNC_ADDR_BIF: bus_rdata <= bif_r;
                `PSYNC_ADDR_CORE: bus_rdata <= {c_r, b_r, a_r};
                // held value returned, no busy raised
                `PSYNC_ADDR_RSYNC: bus_rdata <= {16'h0000, rs_hold_r};
                `PSYNC_ADDR_STAT: bus_rdata <= {15'h0000, cbusy, 2'h0, busy, 7'h00, ready_r};
                default: bus_rdata <= `PSYNC_RST_WORD;
            endcase
        end
        // masked: data stays zero and writes are gated by wr_ok
    end
end

endmodule
`default_nettype wire

// [bench/psync_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psync_defines.vh"
module psync_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scheme_dist,
    input wire logic if_masked,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [2:0] bus_addr,
    input wire logic [3:0] bus_be,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_ready,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_err,
    input wire logic [7:0] core_a,
    input wire logic [15:0] core_c,
    input wire logic core_reset,
    input wire logic sync_busy,
    input wire logic [5:0] sync_pending_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic wr_core = bus_ready && bus_we && bus_addr == `PSYNC_ADDR_CORE;
    wire logic wr_ctrl = bus_ready && bus_we && bus_addr == `PSYNC_ADDR_CTRL;
    a_err_with_ready: assert property (bus_err |-> bus_ready)
        else $error("error flag without answer");
    a_masked_zero: assert property (if_masked [*4] ##0 bus_ready |-> bus_rdata == 32'h0 && !bus_err)
        else $error("masked access not zero");
    a_core_wr_busy: assert property (!scheme_dist && wr_core |-> ##[0:2] sync_busy)
        else $error("core write left busy low");
    a_soft_reset_bit_busy: assert property (!scheme_dist && wr_ctrl && bus_be[0] && bus_wdata[0]
        |-> ##[0:2] sync_busy)
        else $error("soft reset left busy low");
    a_lane_pending: assert property (scheme_dist && wr_core && bus_be[0] && !bus_err
        |-> ##[0:1] sync_pending_flags[`PSYNC_CH_A])
        else $error("write did not mark its channel");
    a_rsync_no_busy: assert property (!scheme_dist && bus_ready && !bus_we
        && bus_addr == `PSYNC_ADDR_RSYNC |-> !sync_busy)
        else $error("read sync raised busy");
    a_soft_reset_bit_stall: assert property (!scheme_dist && sync_pending_flags[`PSYNC_CH_SOFT_RESET_BIT]
        && bus_req && bus_we && !bus_ready |=> !bus_ready)
        else $error("write answered during soft reset");
    a_bif_read_fast: assert property (bus_req && !bus_we && bus_addr == `PSYNC_ADDR_BIF
        && !bus_ready |=> bus_ready)
        else $error("interface read stalled");
    a_reset_clears: assert property (core_reset |-> ##[0:1] (core_a == 8'h00 && core_c == 16'h0000))
        else $error("soft reset left core values");
endmodule
bind psync_top psync_asserts psync_asserts_inst (
    .ref_clk(ref_clk), .resetn(resetn), .scheme_dist(scheme_dist), .if_masked(if_masked),
    .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_err(bus_err),
    .core_a(core_a), .core_c(core_c), .core_reset(core_reset), .sync_busy(sync_busy),
    .sync_pending_flags(sync_pending_flags)
);
`default_nettype wire

// [bench/psync_master.sv]
`timescale 1ns/1ps
`default_nettype none
module psync_master (
    input wire logic ref_clk,
    input wire logic bus_ready,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_err,
    output logic bus_req,
    output logic bus_we,
    output logic [2:0] bus_addr,
    output logic [3:0] bus_be,
    output logic [31:0] bus_wdata
);
    initial begin
        bus_req = 1'b0;
        bus_we = 1'b0;
        bus_addr = 3'h7;
        bus_be = 4'h0;
        bus_wdata = 32'h0;
    end
    // request held until the edge that samples ready; n counts bus cycles
    task xfer(input logic we, input logic [2:0] a, input logic [3:0] be, input logic [31:0] d,
              output logic [31:0] q, output logic e, output int n);
        n = 0;
        @(posedge ref_clk);
        bus_req <= 1'b1;
        bus_we <= we;
        bus_addr <= a;
        bus_be <= be;
        bus_wdata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (bus_ready !== 1'b1 && n < 400);
        q = bus_rdata;
        e = bus_err;
        bus_req <= 1'b0;
        // released lines scramble so stale data never looks valid
        bus_addr <= ~a;
        bus_be <= ~be;
        bus_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [bench/peripheral_register_sync_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "psync_defines.vh"
module peripheral_register_sync_tb_top;
    logic ref_clk, resetn, generic_clock_source_in, scheme_dist, if_masked, bus_req, bus_we;
    logic [15:0] core_rsync_val;
    logic [2:0] bus_addr;
    logic [3:0] bus_be;
    logic [31:0] bus_wdata, bus_rdata, rq;
    logic bus_ready, bus_err, core_enable, core_reset, sync_busy, er;
    logic [7:0] core_a, core_b;
    logic [15:0] core_c;
    logic [5:0] sync_pending_flags;
    int errors, cmp_count, n;
    psync_top psync_top_inst (
        .ref_clk(ref_clk), .resetn(resetn), .generic_clock_source_in(generic_clock_source_in), .scheme_dist(scheme_dist),
        .if_masked(if_masked), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .core_rsync_val(core_rsync_val),
        .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_err(bus_err),
        .core_enable(core_enable), .core_a(core_a), .core_b(core_b), .core_c(core_c),
        .core_reset(core_reset), .sync_busy(sync_busy), .sync_pending_flags(sync_pending_flags)
    );
    psync_master psync_master_inst (
        .ref_clk(ref_clk), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_err(bus_err),
        .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_be(bus_be),
        .bus_wdata(bus_wdata)
    );
    always #4 ref_clk = ~ref_clk;
    // slow generic clock with a phase unrelated to the bus clock
    initial begin
        generic_clock_source_in = 1'b0;
        #3;
        forever #20 generic_clock_source_in = ~generic_clock_source_in;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task wr(input logic [2:0] a, input logic [3:0] be, input logic [31:0] d);
        psync_master_inst.xfer(1'b1, a, be, d, rq, er, n);
    endtask
    task rd(input logic [2:0] a);
        psync_master_inst.xfer(1'b0, a, 4'h0, 32'h0, rq, er, n);
    endtask
    task settle;
        int i;
        i = 0;
        while ((sync_pending_flags !== 6'h00 || sync_busy !== 1'b0) && i < 400) begin
            @(posedge ref_clk);
            i++;
        end
        chk(i < 400, 1'b1);
        repeat (3) @(posedge ref_clk);
    endtask
    task t_dist;
        scheme_dist <= 1'b1;
        settle;
        wr(`PSYNC_ADDR_CORE, 4'h1, 32'h5A);
        chk(er, 1'b0);
        #1 chk(sync_pending_flags[`PSYNC_CH_A], 1'b1);
        wr(`PSYNC_ADDR_CORE, 4'h2, 32'hA500);
        chk(er, 1'b0);
        wr(`PSYNC_ADDR_CORE, 4'h1, 32'h33);
        chk(er, 1'b1);
        rd(`PSYNC_ADDR_STAT);
        chk(rq[0], 1'b0);
        settle;
        chk({core_b, core_a}, 16'hA55A);
        rd(`PSYNC_ADDR_STAT);
        chk(rq[0], 1'b1);
        $display("done t_dist");
    endtask
    task t_half;
        wr(`PSYNC_ADDR_CORE, 4'h4, 32'h00110000);
        chk(er, 1'b0);
        wr(`PSYNC_ADDR_CORE, 4'h8, 32'h22000000);
        chk(er, 1'b1);
        settle;
        chk(core_c, 16'h0011);
        wr(`PSYNC_ADDR_CORE, 4'hF, 32'h44332211);
        chk(er, 1'b0);
        settle;
        chk({core_c, core_b, core_a}, 32'h44332211);
        core_rsync_val <= 16'hBEEF;
        repeat (5) @(posedge ref_clk);
        chk(sync_pending_flags[`PSYNC_CH_RSYNC], 1'b1);
        settle;
        rd(`PSYNC_ADDR_RSYNC);
        chk(n, 2);
        chk(rq, 32'h0000BEEF);
        $display("done t_half");
    endtask
    task t_enable;
        wr(`PSYNC_ADDR_STAT, 4'h1, 32'h1);
        wr(`PSYNC_ADDR_CTRL, 4'h1, 32'h2);
        rd(`PSYNC_ADDR_CTRL);
        chk(rq[1], 1'b1);
        chk(sync_pending_flags[`PSYNC_CH_ENABLE], 1'b1);
        settle;
        chk(core_enable, 1'b1);
        rd(`PSYNC_ADDR_STAT);
        chk(rq[0], 1'b0);
        wr(`PSYNC_ADDR_CTRL, 4'h1, 32'h3);
        rd(`PSYNC_ADDR_CTRL);
        chk(rq[0], 1'b1);
        chk(sync_pending_flags[`PSYNC_CH_SOFT_RESET_BIT], 1'b1);
        settle;
        rd(`PSYNC_ADDR_CTRL);
        chk(rq[1:0], 2'h0);
        chk({core_c, core_b, core_a}, 32'h0);
        chk(core_enable, 1'b0);
        rd(`PSYNC_ADDR_STAT);
        chk(rq[0], 1'b0);
        wr(`PSYNC_ADDR_CTRL, 4'h1, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(sync_pending_flags, 6'h00);
        $display("done t_enable");
    endtask
    task t_common;
        scheme_dist <= 1'b0;
        wr(`PSYNC_ADDR_BIF, 4'hF, 32'hC0DE1234);
        settle;
        wr(`PSYNC_ADDR_CORE, 4'h1, 32'h77);
        rd(`PSYNC_ADDR_BIF);
        chk(n, 2);
        chk(sync_busy, 1'b1);
        wr(`PSYNC_ADDR_CORE, 4'h2, 32'h8800);
        chk(n > 2, 1'b1);
        chk(core_a, 8'h77);
        settle;
        wr(`PSYNC_ADDR_CTRL, 4'h1, 32'h1);
        rd(`PSYNC_ADDR_CTRL);
        chk(rq[0], 1'b1);
        rd(`PSYNC_ADDR_BIF);
        chk(n, 2);
        chk(rq, 32'hC0DE1234);
        chk(sync_busy, 1'b1);
        wr(`PSYNC_ADDR_BIF, 4'hF, 32'h1);
        chk(n > 2, 1'b1);
        chk(core_a, 8'h00);
        rd(`PSYNC_ADDR_CTRL);
        chk(rq[0], 1'b0);
        rd(`PSYNC_ADDR_RSYNC);
        chk(n > 27 && n < 33, 1'b1);
        chk(rq, 32'h0000BEEF);
        $display("done t_common");
    endtask
    task t_mask;
        if_masked <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(`PSYNC_ADDR_BIF);
        chk(rq, 32'h0);
        wr(`PSYNC_ADDR_BIF, 4'hF, 32'hFF);
        if_masked <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rd(`PSYNC_ADDR_BIF);
        chk(rq, 32'h1);
        $display("done t_mask");
    endtask
    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        scheme_dist = 1'b0;
        if_masked = 1'b0;
        core_rsync_val = 16'h0000;
        errors = 0;
        cmp_count = 0;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_dist;
        t_half;
        t_enable;
        t_common;
        t_mask;
        summarize;
    end
    // whole run needs several hundred cycles
    initial begin
        #200000;
        errors++;
        summarize;
    end
endmodule
`default_nettype wire
